// ===== jsep_fifo.sv
// jsep_pkg constants and the jsep_fifo stream buffer.
// assumes one clock and a synchronous active-low reset on the fifo side.
package jsep_pkg;
  localparam int          IR_W       = 4;
  localparam logic [3:0]  IR_BYPASS  = 4'hF;
  localparam logic [3:0]  IR_IDCODE  = 4'h1;
  localparam logic [3:0]  IR_EMUCTL  = 4'h2;
  localparam logic [3:0]  IR_STREAM  = 4'h3;
  localparam logic [3:0]  IR_CAPTURE = 4'h1;
  localparam int          DR_W       = 32;
  localparam int          IDCODE_LEN = 32;
  localparam int          EMUCTL_LEN = 2;
  localparam int          STREAM_W   = 8;
  localparam int          STREAM_LEN = 8;
  localparam int          FIFO_DEPTH = 8;
  // value is arbitrary, lsb set as a capture marker
  localparam logic [31:0] IDCODE_VAL = 32'h0F0F_0001;
  localparam logic [1:0]  EMU_DIR_RST = 2'h0;
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } jsep_tap_e;
endpackage

////////////////////////////////////////////////////////////////////////////
module jsep_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
    $error("fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [AW:0]      wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
  logic             doWrite, doRead;

  // extra pointer bit tells full from empty
  assign inReady  = (wrPtr_reg[AW] == rdPtr_reg[AW]) ||
                    (wrPtr_reg[AW-1:0] != rdPtr_reg[AW-1:0]);
  assign outValid = wrPtr_reg != rdPtr_reg;
  assign outData  = mem_reg[rdPtr_reg[AW-1:0]];
  assign doWrite  = inValid && inReady;
  assign doRead   = outValid && outReady;

  always_comb begin
    mem_next   = mem_reg;
    wrPtr_next = wrPtr_reg;
    rdPtr_next = rdPtr_reg;
    if (doWrite) begin
      mem_next[wrPtr_reg[AW-1:0]] = inData;
      wrPtr_next = wrPtr_reg + 1'b1;
    end
    if (doRead) begin
      rdPtr_next = rdPtr_reg + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    mem_reg <= mem_next;
    if (!rstn) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
    end else begin
      wrPtr_reg <= wrPtr_next;
      rdPtr_reg <= rdPtr_next;
    end
  end
endmodule

// ===== jsep_port.sv
// jsep_port: test access port with emulator sideband and a scan stream.
// assumes tck, tms, tdi, trst come from the debugger pod; mclk is system.
// Notes on behaviour
// - tms sampled on rising tck
// - tdi shifted into selected register on rising
// - tdo changes on falling tck edge
// - trst high: emulator lines with direction bit 0 (inputs) carry interrupts
// - emulator line direction loaded through scan
// - trst rise, line0 high, line1 low: boundary-scan
// - trst low keeps functional mode, test ignored
module jsep_port (
  input  wire logic                         mclk,
  input  wire logic                         rstn,
  input  wire logic                         tck,
  input  wire logic                         tms,
  input  wire logic                         tdi,
  input  wire logic                         trst,
  output logic                              tdoOut,
  output logic                              tdoOe,
  input  wire logic [1:0]                   emuIn,
  output logic      [1:0]                   emuOut,
  output logic      [1:0]                   emuOe,
  input  wire logic [1:0]                   emuEvent,
  output logic      [1:0]                   emuIrq,
  output logic                              scanActive,
  output logic                              bscanMode,
  output logic      [jsep_pkg::STREAM_W-1:0] streamData,
  output logic                              streamValid,
  input  wire logic                         streamReady
);
  function automatic int drLen(input logic [3:0] ir);
    unique case (ir)
      jsep_pkg::IR_IDCODE: drLen = jsep_pkg::IDCODE_LEN;
      jsep_pkg::IR_EMUCTL: drLen = jsep_pkg::EMUCTL_LEN;
      jsep_pkg::IR_STREAM: drLen = jsep_pkg::STREAM_LEN;
      default:             drLen = 1;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // link domain on tck; trst low holds it in reset
  jsep_pkg::jsep_tap_e           tap_reg, tap_next;
  logic [3:0]                    ir_reg, ir_next, irSh_reg, irSh_next;
  logic [jsep_pkg::DR_W-1:0]     dr_reg, dr_next;
  logic [1:0]                    dir_reg, dir_next;
  logic [jsep_pkg::STREAM_W-1:0] hold_reg, hold_next;
  logic                          req_reg, req_next;
  logic                          ackS1_reg, ackS2_reg;
  logic                          tdo_next, oe_next, busy;
  logic                          ack_reg, ack_next;

  assign busy = req_reg ^ ackS2_reg;

  always_comb begin
    int len;
    len      = drLen(ir_reg);
    tap_next = tap_reg;
    ir_next  = ir_reg;
    irSh_next = irSh_reg;
    dr_next  = dr_reg;
    dir_next = dir_reg;
    hold_next = hold_reg;
    req_next = req_reg;
    unique case (tap_reg)
      jsep_pkg::TAP_RESET:    tap_next = tms ? jsep_pkg::TAP_RESET
                                             : jsep_pkg::TAP_IDLE;
      jsep_pkg::TAP_IDLE:     tap_next = tms ? jsep_pkg::TAP_SEL_DR
                                             : jsep_pkg::TAP_IDLE;
      jsep_pkg::TAP_SEL_DR:   tap_next = tms ? jsep_pkg::TAP_SEL_IR
                                             : jsep_pkg::TAP_CAP_DR;
      jsep_pkg::TAP_CAP_DR,
      jsep_pkg::TAP_SHIFT_DR: tap_next = tms ? jsep_pkg::TAP_EXIT1_DR
                                             : jsep_pkg::TAP_SHIFT_DR;
      jsep_pkg::TAP_EXIT1_DR: tap_next = tms ? jsep_pkg::TAP_UPD_DR
                                             : jsep_pkg::TAP_PAUSE_DR;
      jsep_pkg::TAP_PAUSE_DR: tap_next = tms ? jsep_pkg::TAP_EXIT2_DR
                                             : jsep_pkg::TAP_PAUSE_DR;
      jsep_pkg::TAP_EXIT2_DR: tap_next = tms ? jsep_pkg::TAP_UPD_DR
                                             : jsep_pkg::TAP_SHIFT_DR;
      jsep_pkg::TAP_UPD_DR,
      jsep_pkg::TAP_UPD_IR:   tap_next = tms ? jsep_pkg::TAP_SEL_DR
                                             : jsep_pkg::TAP_IDLE;
      jsep_pkg::TAP_SEL_IR:   tap_next = tms ? jsep_pkg::TAP_RESET
                                             : jsep_pkg::TAP_CAP_IR;
      jsep_pkg::TAP_CAP_IR,
      jsep_pkg::TAP_SHIFT_IR: tap_next = tms ? jsep_pkg::TAP_EXIT1_IR
                                             : jsep_pkg::TAP_SHIFT_IR;
      jsep_pkg::TAP_EXIT1_IR: tap_next = tms ? jsep_pkg::TAP_UPD_IR
                                             : jsep_pkg::TAP_PAUSE_IR;
      jsep_pkg::TAP_PAUSE_IR: tap_next = tms ? jsep_pkg::TAP_EXIT2_IR
                                             : jsep_pkg::TAP_PAUSE_IR;
      jsep_pkg::TAP_EXIT2_IR: tap_next = tms ? jsep_pkg::TAP_UPD_IR
                                             : jsep_pkg::TAP_SHIFT_IR;
    endcase
    unique case (tap_reg)
      jsep_pkg::TAP_RESET:    ir_next = jsep_pkg::IR_IDCODE;
      jsep_pkg::TAP_CAP_IR:   irSh_next = jsep_pkg::IR_CAPTURE;
      jsep_pkg::TAP_SHIFT_IR: irSh_next = {tdi, irSh_reg[3:1]};
      jsep_pkg::TAP_UPD_IR:   ir_next = irSh_reg;
      jsep_pkg::TAP_CAP_DR: begin
        unique case (ir_reg)
          jsep_pkg::IR_IDCODE: dr_next = jsep_pkg::IDCODE_VAL;
          jsep_pkg::IR_EMUCTL: dr_next = {30'h0000_0000, dir_reg};
          // first bit out tells the pod the stream is still busy
          jsep_pkg::IR_STREAM: dr_next = {31'h0000_0000, busy};
          default:             dr_next = '0;
        endcase
      end
      jsep_pkg::TAP_SHIFT_DR: begin
        for (int i = 0; i < jsep_pkg::DR_W; i++) begin
          if (i == len - 1) begin
            dr_next[i] = tdi;
          end else if (i < len - 1) begin
            dr_next[i] = dr_reg[i + 1];
          end else begin
            dr_next[i] = 1'b0;
          end
        end
      end
      jsep_pkg::TAP_UPD_DR: begin
        if (ir_reg == jsep_pkg::IR_EMUCTL) begin
          dir_next = dr_reg[1:0];
        end
        // a busy stream drops the word; pod polls the busy bit
        if (ir_reg == jsep_pkg::IR_STREAM && !busy) begin
          hold_next = dr_reg[jsep_pkg::STREAM_W-1:0];
          req_next  = ~req_reg;
        end
      end
      default: ;
    endcase
  end

  always_ff @(posedge tck or negedge trst) begin
    if (!trst) begin
      tap_reg   <= jsep_pkg::TAP_RESET;
      ir_reg    <= jsep_pkg::IR_IDCODE;
      irSh_reg  <= '0;
      dr_reg    <= '0;
      dir_reg   <= jsep_pkg::EMU_DIR_RST;
      hold_reg  <= '0;
      req_reg   <= 1'b0;
      ackS1_reg <= 1'b0;
      ackS2_reg <= 1'b0;
    end else begin
      tap_reg   <= tap_next;
      ir_reg    <= ir_next;
      irSh_reg  <= irSh_next;
      dr_reg    <= dr_next;
      dir_reg   <= dir_next;
      hold_reg  <= hold_next;
      req_reg   <= req_next;
      ackS1_reg <= ack_reg;
      ackS2_reg <= ackS1_reg;
    end
  end

  always_comb begin
    oe_next  = tap_reg == jsep_pkg::TAP_SHIFT_DR ||
               tap_reg == jsep_pkg::TAP_SHIFT_IR;
    tdo_next = (tap_reg == jsep_pkg::TAP_SHIFT_IR) ? irSh_reg[0] : dr_reg[0];
  end

  always_ff @(negedge tck or negedge trst) begin
    if (!trst) begin
      tdoOut <= 1'b0;
      tdoOe  <= 1'b0;
    end else begin
      tdoOut <= tdo_next;
      tdoOe  <= oe_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // system domain on mclk
  logic       trS1_reg, trS2_reg, trPrev_reg;
  logic [1:0] eS1_reg, eS2_reg, dS1_reg, dS2_reg;
  logic       rqS1_reg, rqS2_reg;
  logic       bscan_next, pending, fifoReady, trRise;
  logic [1:0] irq_next, oe2_next;

  assign trRise  = trS2_reg && !trPrev_reg;
  assign pending = rqS2_reg ^ ack_reg;

  always_comb begin
    if (!trS2_reg) begin
      bscan_next = 1'b0;
    end else if (trRise && eS2_reg[0] && !eS2_reg[1]) begin
      bscan_next = 1'b1;
    end else begin
      bscan_next = bscanMode;
    end
    irq_next = eS2_reg & ~dS2_reg & {2{trS2_reg}};
    oe2_next = dS2_reg & {2{trS2_reg}};
    ack_next = (pending && fifoReady) ? ~ack_reg : ack_reg;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      trS1_reg   <= 1'b0;
      trS2_reg   <= 1'b0;
      trPrev_reg <= 1'b0;
      eS1_reg    <= 2'h0;
      eS2_reg    <= 2'h0;
      dS1_reg    <= 2'h0;
      dS2_reg    <= 2'h0;
      rqS1_reg   <= 1'b0;
      rqS2_reg   <= 1'b0;
      ack_reg    <= 1'b0;
      bscanMode  <= 1'b0;
      scanActive <= 1'b0;
      emuIrq     <= 2'h0;
      emuOe      <= 2'h0;
      emuOut     <= 2'h0;
    end else begin
      trS1_reg   <= trst;
      trS2_reg   <= trS1_reg;
      trPrev_reg <= trS2_reg;
      eS1_reg    <= emuIn;
      eS2_reg    <= eS1_reg;
      dS1_reg    <= dir_reg;
      dS2_reg    <= dS1_reg;
      rqS1_reg   <= req_reg;
      rqS2_reg   <= rqS1_reg;
      ack_reg    <= ack_next;
      bscanMode  <= bscan_next;
      scanActive <= trS2_reg;
      emuIrq     <= irq_next;
      emuOe      <= oe2_next;
      emuOut     <= emuEvent;
    end
  end

  // full fifo withholds the ack, so the tck side stays busy
  jsep_fifo #(
    .WIDTH (jsep_pkg::STREAM_W),
    .DEPTH (jsep_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk     (mclk),
    .rstn     (rstn),
    .inData   (hold_reg),
    .inValid  (pending),
    .inReady  (fifoReady),
    .outData  (streamData),
    .outValid (streamValid),
    .outReady (streamReady)
  );

  ////////////////////////////////////////////////////////////////////////////
  sequence s_fiveOnes;
    tms [*5];
  endsequence

  property p_tmsReset;
    @(posedge tck) disable iff (!trst)
      s_fiveOnes |=> tap_reg == jsep_pkg::TAP_RESET;
  endproperty
  a_tmsReset: assert property (p_tmsReset)
    else $error("five tms ones did not reach reset");

  property p_tmsIdle;
    @(posedge tck) disable iff (!trst)
      (tap_reg == jsep_pkg::TAP_RESET && !tms) |=>
        tap_reg == jsep_pkg::TAP_IDLE;
  endproperty
  a_tmsIdle: assert property (p_tmsIdle)
    else $error("tms low in reset did not go idle");

  property p_bypassShift;
    @(posedge tck) disable iff (!trst)
      (tap_reg == jsep_pkg::TAP_SHIFT_DR && ir_reg == jsep_pkg::IR_BYPASS)
        |=> dr_reg[0] == $past(tdi);
  endproperty
  a_bypassShift: assert property (p_bypassShift)
    else $error("bypass did not take tdi");

  property p_irShift;
    @(posedge tck) disable iff (!trst)
      tap_reg == jsep_pkg::TAP_SHIFT_IR |=> irSh_reg[3] == $past(tdi);
  endproperty
  a_irShift: assert property (p_irShift)
    else $error("instruction did not take tdi");

  property p_tdoFall;
    @(posedge tck) disable iff (!trst)
      tap_reg == jsep_pkg::TAP_SHIFT_DR |-> tdoOe && tdoOut == dr_reg[0];
  endproperty
  a_tdoFall: assert property (p_tdoFall)
    else $error("tdo not set from the falling edge");

  property p_irqGate;
    @(posedge mclk) disable iff (!rstn)
      emuIrq != 2'h0 |-> $past(trS2_reg) && (emuOe & emuIrq) == 2'h0;
  endproperty
  a_irqGate: assert property (p_irqGate)
    else $error("interrupt seen without test reset");

  property p_dirLoad;
    @(posedge tck) disable iff (!trst)
      (tap_reg == jsep_pkg::TAP_UPD_DR && ir_reg == jsep_pkg::IR_EMUCTL)
        |=> dir_reg == $past(dr_reg[1:0]);
  endproperty
  a_dirLoad: assert property (p_dirLoad)
    else $error("direction not loaded from scan");

  sequence s_bscanEntry;
    trRise && eS2_reg == 2'h1;
  endsequence

  property p_bscan;
    @(posedge mclk) disable iff (!rstn)
      s_bscanEntry |=> bscanMode;
  endproperty
  a_bscan: assert property (p_bscan)
    else $error("boundary-scan mode not latched");

  property p_functional;
    @(posedge mclk) disable iff (!rstn)
      !trS2_reg |=> !bscanMode && !scanActive && emuOe == 2'h0;
  endproperty
  a_functional: assert property (p_functional)
    else $error("test control active with trst low");
endmodule

// ===== jsep_pod.sv
// jsep_pod: behavioural debugger pod for the test port.
// assumes the bench calls its tasks; tck stands still between scans.
module jsep_pod (
  output logic       tck,
  output logic       tms,
  output logic       tdi,
  output logic       trst,
  output logic [1:0] emuDrv,
  output logic [1:0] emuDrvOe,
  input  wire logic  tdoOut
);
  timeunit 1ns;
  timeprecision 100ps;
  int badEdge = 0;

  initial begin
    {tck, tms, tdi, trst} = 4'h0;
    emuDrv = 2'h0;
    emuDrvOe = 2'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // levels stable across rise
  task automatic tick(input logic m, input logic d, output logic o);
    logic held;
    tms = m;
    tdi = d;
    #7.5 o = tdoOut;
    tck = 1'b1;
    #1 held = tdoOut;
    if (held !== o) badEdge++;
    #6.5 tck = 1'b0;
  endtask

  task automatic tap_reset();
    logic o;
    repeat (5) tick(1'b1, 1'b0, o);
    tick(1'b0, 1'b0, o);
  endtask

  // lsb first, from idle back to idle
  task automatic scan(input logic ir, input logic [31:0] din, input int n,
                      output logic [31:0] dout);
    logic o;
    dout = '0;
    tick(1'b1, 1'b0, o);
    if (ir) tick(1'b1, 1'b0, o);
    tick(1'b0, 1'b0, o);
    tick(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], o);
      dout[i] = o;
    end
    tick(1'b1, 1'b0, o);
    // idle ticks let the stream handshake return
    repeat (4) tick(1'b0, 1'b0, o);
  endtask

  task automatic pins(input logic t, input logic [1:0] v,
                      input logic [1:0] oe);
    emuDrv = v;
    emuDrvOe = oe;
    #20 trst = t;
  endtask
endmodule

// ===== testbench.sv
// testbench: self-checking bench for jsep_port with the pod model.
// assumes jsep_pkg and jsep_port are compiled first.
`define CHK(what, exp, got) begin compares++; if ((got) !== (exp)) begin \
  error_cnt++; $display("unexpected %s: expected %0h seen %0h", what, \
  exp, got); end end

module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    logic [3:0]  ir;
    logic [31:0] din;
    int          len;
    logic [31:0] exp;
    logic [31:0] mask;
  } jsep_row_s;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic [1:0]  emuEvent = 2'h0;
  logic        streamReady = 1'b0;
  logic        tck, tms, tdi, trst, tdoOut, tdoOe, scanActive, bscanMode;
  logic [1:0]  emuIn, emuOut, emuOe, emuIrq, emuDrv, emuDrvOe;
  logic [7:0]  streamData;
  logic        streamValid;
  logic [31:0] d;
  int          error_cnt = 0;
  int          compares = 0;
  int          cycles = 0;
  jsep_row_s   rows [4] = '{
    '{jsep_pkg::IR_IDCODE, 32'h0, 32, jsep_pkg::IDCODE_VAL, 32'hFFFFFFFF},
    '{jsep_pkg::IR_BYPASS, 32'h1, 2, 32'h2, 32'h3},
    '{jsep_pkg::IR_EMUCTL, 32'h1, 2, 32'h0, 32'h3},
    '{jsep_pkg::IR_STREAM, 32'hA5, 8, 32'h0, 32'h1}};

  // emulator lines carry pull-ups
  assign emuIn = (emuOe & emuOut) | (~emuOe & emuDrvOe & emuDrv)
               | (~emuOe & ~emuDrvOe);

  jsep_port DUT (.mclk(mclk), .rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi),
    .trst(trst), .tdoOut(tdoOut), .tdoOe(tdoOe), .emuIn(emuIn),
    .emuOut(emuOut), .emuOe(emuOe), .emuEvent(emuEvent), .emuIrq(emuIrq),
    .scanActive(scanActive), .bscanMode(bscanMode),
    .streamData(streamData), .streamValid(streamValid),
    .streamReady(streamReady));
  jsep_pod pod (.tck(tck), .tms(tms), .tdi(tdi), .trst(trst),
    .emuDrv(emuDrv), .emuDrvOe(emuDrvOe), .tdoOut(tdoOut));

  initial begin
    forever #5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // ceiling well above the roughly 700 cycles of the run
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      close_out();
    end
  end

  initial begin
    int n;
    wait_clk(16);
    rstn = 1'b1;
    wait_clk(2);
    `CHK("bscanMode", 1'b0, bscanMode)
    `CHK("scanActive", 1'b0, scanActive)
    pod.pins(1'b1, 2'h0, 2'h0);
    pod.tap_reset();
    foreach (rows[i]) begin
      pod.scan(1'b1, {28'h0, rows[i].ir}, 4, d);
      `CHK("ir capture", jsep_pkg::IR_CAPTURE, d[3:0])
      pod.scan(1'b0, rows[i].din, rows[i].len, d);
      `CHK("dr out", rows[i].exp & rows[i].mask, d & rows[i].mask)
    end
    wait_clk(20);
    `CHK("stream word", 8'hA5, streamData)
    `CHK("emuOe", 2'h1, emuOe)
    pod.pins(1'b1, 2'h2, 2'h2);
    emuEvent = 2'h1;
    wait_clk(10);
    `CHK("emuIrq", 2'h2, emuIrq)
    `CHK("emuOut", 2'h1, emuOut)
    for (int k = 1; k <= 9; k++) begin
      pod.scan(1'b0, 32'hA5 + k, 8, d);
      wait_clk(10);
    end
    `CHK("busy capture", 1'b1, d[0])
    streamReady = 1'b1;
    for (int j = 0; j < 9; j++) begin
      n = 0;
      while (streamValid !== 1'b1 && n < 50) begin
        wait_clk(1);
        n++;
      end
      `CHK("drain word", 8'hA5 + j, streamData)
      wait_clk(1);
    end
    wait_clk(30);
    `CHK("dropped word", 1'b0, streamValid)
    pod.pins(1'b0, 2'h1, 2'h3);
    wait_clk(10);
    `CHK("scanActive low", 1'b0, scanActive)
    `CHK("emuOe low", 2'h0, emuOe)
    pod.scan(1'b0, 32'h3C, 8, d);
    wait_clk(20);
    `CHK("tdoOe low", 1'b0, tdoOe)
    `CHK("no push", 1'b0, streamValid)
    pod.pins(1'b1, 2'h1, 2'h3);
    wait_clk(10);
    `CHK("bscan set", 1'b1, bscanMode)
    `CHK("scanActive", 1'b1, scanActive)
    pod.pins(1'b0, 2'h3, 2'h3);
    wait_clk(10);
    `CHK("bscan cleared", 1'b0, bscanMode)
    pod.pins(1'b1, 2'h3, 2'h3);
    wait_clk(10);
    `CHK("bscan wrong lines", 1'b0, bscanMode)
    `CHK("emuIrq inputs", 2'h3, emuIrq)
    `CHK("tdo edge", 0, pod.badEdge)
    close_out();
  end
endmodule
